// [sac_ctrl.sv]
// Successive approximation converter sequencer and result formatter
`timescale 1ns/1ps
`include "sac_defines.svh"
// Operation
// - 12-bit result, one trial per bit, MSB first
// - Three input modes set pairing and coding
// - Software single or continuous conversions
// - Pin, logic array, timer overflow triggers
// - Trigger still high restarts conversion
// - Single-ended and pseudo results straight binary
// - Fully differential results twos complement
// - Sequencing sustains one megasample per second
// - Temperature channel selectable like others
// - Gain pairs get 32-step gain field
// - General channels single-ended or differential
// - Input buffer usable for internal channels
// - Result in bits 27:16, sign above
// - Differential result shifted right one bit
// - Temperature forces 16 acquire, divider 32
// - Reset: acquire 8, divider 2, 19 extra
module sac_ctrl #(
  parameter int RES_W = `SAC_RES_BITS
) (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // Configuration
  input  wire sac_pkg::sac_mode_t       mode,
  input  wire sac_pkg::sac_trig_t       trig_sel,
  input  wire logic                     continuous,
  input  wire logic                     sw_start,
  input  wire logic [`SAC_CHAN_W-1:0]   channel,
  input  wire logic [`SAC_GAIN_W-1:0]   gain_code,
  input  wire logic                     chan_diff,
  input  wire logic                     buf_bypass_p,
  input  wire logic                     buf_bypass_n,
  input  wire logic                     timing_load,
  input  wire logic [7:0]               acq_clks,
  input  wire logic [7:0]               clk_div,
  // Trigger sources
  input  wire logic                     conversion_start_pin,
  input  wire logic                     programmable_logic_array,
  input  wire logic                     first_timer_overflow,
  input  wire logic                     second_timer_overflow,
  // Analog side
  input  wire logic                     cmp_out,
  output logic [RES_W-1:0]              dac_code,
  output logic                          sample,
  output logic [`SAC_CHAN_W-1:0]        mux_sel,
  output logic [`SAC_GAIN_W-1:0]        gain_amplifier,
  output logic                          pair_diff,
  output logic                          buf_en_p,
  output logic                          buf_en_n,
  // Result stream and status
  output logic [31:0]                   conversion_result_word,
  output logic                          result_valid,
  input  wire logic                     result_ready,
  input  wire logic                     result_read,
  output logic                          conv_done,
  output logic                          busy
);
  // One packed state record
  typedef struct packed {
    sac_pkg::sac_state_t st;
    logic [7:0]  acq;      // user acquisition clocks
    logic [7:0]  div;      // user clock divider
    logic [7:0]  dcnt;     // divider counter
    logic [7:0]  ccnt;     // clock counter within phase
    logic [RES_W-1:0] sar; // trial register
    logic [3:0]  bit_i;    // current trial bit
    logic        temp;     // conversion on temperature channel
    logic        trig_d;   // trigger delayed for edge
    logic        run;      // continuous mode active
    logic        done;     // sticky done flag
    logic [1:0][31:0] buf_w; // two-entry result buffer
    logic        wr_p;
    logic        rd_p;
    logic [1:0]  cnt;
    logic [31:0] word;
  } sac_reg_t;

  sac_reg_t q, d;

  // Selected trigger level
  function automatic logic trig_level(input sac_pkg::sac_trig_t s,
                                      input logic a, input logic b,
                                      input logic c, input logic e);
    unique case (s)
      sac_pkg::SAC_TRIG_PIN:  trig_level = a;
      sac_pkg::SAC_TRIG_PLA:  trig_level = b;
      sac_pkg::SAC_TRIG_TMR0: trig_level = c;
      sac_pkg::SAC_TRIG_TMR1: trig_level = e;
      default:                trig_level = 1'b0;
    endcase
  endfunction

  logic trig;
  logic start;
  logic [7:0] acq_eff;
  logic [7:0] div_eff;
  logic tick;
  logic full;
  logic push;
  logic pop;
  logic [RES_W-1:0] res;
  logic [31:0] fmt;

  // Trigger and effective timing
  always_comb begin
    trig = trig_level(trig_sel, conversion_start_pin,
                      programmable_logic_array,
                      first_timer_overflow, second_timer_overflow);
    start = (trig_sel == sac_pkg::SAC_TRIG_SW) ?
            (sw_start | q.run) : (trig & ~q.trig_d);
    acq_eff = q.temp ? `SAC_ACQ_TEMP : q.acq;
    div_eff = q.temp ? `SAC_DIV_TEMP : q.div;
    tick = (q.dcnt >= div_eff - 8'h01);
    full = (q.cnt == 2'h2);
    pop = result_valid & result_ready;
    res = q.sar;
    // Coding per mode
    if (mode == sac_pkg::SAC_MODE_DIFF) begin
      res = q.sar ^ {1'b1, {(RES_W-1){1'b0}}};
      fmt = {{5{res[RES_W-1]}}, res, 15'h0000};
    end else begin
      fmt = {4'h0, res, 16'h0000};
    end
  end

  // Next state
  always_comb begin
    d = q;
    push = 1'b0; // Raised only by the write step
    d.trig_d = trig;
    d.dcnt = tick ? 8'h00 : q.dcnt + 8'h01;
    if (timing_load && q.st == sac_pkg::SAC_ST_IDLE) begin
      d.acq = acq_clks;
      d.div = (clk_div == 8'h00) ? 8'h01 : clk_div;
    end
    if (sw_start && trig_sel == sac_pkg::SAC_TRIG_SW)
      d.run = continuous;
    if (!continuous)
      d.run = 1'b0;
    unique case (q.st)
      sac_pkg::SAC_ST_IDLE: begin
        if (start && !full) begin
          d.st = sac_pkg::SAC_ST_ACQ;
          d.temp = (channel == `SAC_TEMP_CHAN);
          d.ccnt = 8'h00;
          d.dcnt = 8'h00;
        end
      end
      sac_pkg::SAC_ST_ACQ: begin
        if (tick) begin
          d.ccnt = q.ccnt + 8'h01;
          if (q.ccnt == acq_eff - 8'h01) begin
            d.st = sac_pkg::SAC_ST_TRIAL;
            d.bit_i = 4'(RES_W - 1);
            d.sar = {1'b1, {(RES_W-1){1'b0}}};
            d.ccnt = 8'h00;
          end
        end
      end
      sac_pkg::SAC_ST_TRIAL: begin
        if (tick) begin
          d.ccnt = q.ccnt + 8'h01;
          if (q.ccnt < 8'(RES_W)) begin
            d.sar[q.bit_i] = cmp_out;
            if (q.bit_i != 4'h0) begin
              d.sar[q.bit_i - 4'h1] = 1'b1;
              d.bit_i = q.bit_i - 4'h1;
            end
          end
          if (q.ccnt == `SAC_EXTRA_CLKS - 8'h02)
            d.st = sac_pkg::SAC_ST_WRITE;
        end
      end
      sac_pkg::SAC_ST_WRITE: begin
        if (tick && !full) begin
          push = 1'b1;
          d.done = 1'b1;
          d.temp = 1'b0;
          // Held trigger restarts at once
          if ((trig_sel != sac_pkg::SAC_TRIG_SW && trig) || q.run) begin
            d.st = sac_pkg::SAC_ST_ACQ;
            d.temp = (channel == `SAC_TEMP_CHAN);
            d.ccnt = 8'h00;
          end else begin
            d.st = sac_pkg::SAC_ST_IDLE;
          end
        end
      end
    endcase
    // Read clears, a new result wins
    if (result_read && !push)
      d.done = 1'b0;
    if (push) begin
      d.buf_w[q.wr_p] = fmt;
      d.wr_p = ~q.wr_p;
    end
    if (pop) begin
      d.rd_p = ~q.rd_p;
      d.word = q.buf_w[q.rd_p];
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
      q.acq <= `SAC_ACQ_RESET;
      q.div <= `SAC_DIV_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs
  always_comb begin
    dac_code = q.sar;
    sample = (q.st == sac_pkg::SAC_ST_ACQ);
    mux_sel = channel;
    gain_amplifier = gain_code;
    pair_diff = chan_diff | (mode == sac_pkg::SAC_MODE_DIFF);
    buf_en_p = ~buf_bypass_p | (channel >= 4'hc);
    buf_en_n = ~buf_bypass_n | (channel >= 4'hc);
    conversion_result_word = q.word;
    result_valid = (q.cnt != 2'h0);
    conv_done = q.done;
    busy = (q.st != sac_pkg::SAC_ST_IDLE);
  end
endmodule // sac_ctrl

// [sac_defines.svh]
// Timing counts, field positions and reset values of the converter control
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH
`define SAC_RES_BITS        12
`define SAC_ACQ_RESET       8'h08
`define SAC_DIV_RESET       8'h02
`define SAC_ACQ_TEMP        8'h10
`define SAC_DIV_TEMP        8'h20
`define SAC_EXTRA_CLKS      8'h13
`define SAC_RES_LSB         16
`define SAC_RES_MSB         27
`define SAC_GAIN_W          5
`define SAC_CHAN_W          4
`define SAC_TEMP_CHAN       4'hf
`endif

// [sac_pkg.sv]
// Types shared by the converter control logic
package sac_pkg;
  // Input configuration
  typedef enum logic [1:0] {
    SAC_MODE_SINGLE = 2'b00,
    SAC_MODE_DIFF   = 2'b01,
    SAC_MODE_PSEUDO = 2'b10
  } sac_mode_t;
  // Trigger source select
  typedef enum logic [2:0] {
    SAC_TRIG_SW     = 3'b000,
    SAC_TRIG_PIN    = 3'b001,
    SAC_TRIG_PLA    = 3'b010,
    SAC_TRIG_TMR0   = 3'b011,
    SAC_TRIG_TMR1   = 3'b100
  } sac_trig_t;
  // Sequencer states
  typedef enum logic [1:0] {
    SAC_ST_IDLE  = 2'b00,
    SAC_ST_ACQ   = 2'b01,
    SAC_ST_TRIAL = 2'b10,
    SAC_ST_WRITE = 2'b11
  } sac_state_t;
endpackage

// [sac_ctrl_asserts.sv]
// Concurrent checks on the converter control ports
`timescale 1ns/1ps
module sac_ctrl_asserts (
  input wire logic               mclk,
  input wire logic               rst,
  input wire sac_pkg::sac_trig_t trig_sel,
  input wire logic               continuous,
  input wire logic               sw_start,
  input wire logic [3:0]         channel,
  input wire logic [4:0]         gain_code,
  input wire logic               conversion_start_pin,
  input wire logic               sample,
  input wire logic [4:0]         gain_amplifier,
  input wire logic               buf_en_p,
  input wire logic               buf_en_n,
  input wire logic [31:0]        conversion_result_word,
  input wire logic               result_valid,
  input wire logic               result_ready,
  input wire logic               result_read,
  input wire logic               conv_done,
  input wire logic               busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Two cycles with no word leaving the buffer
  sequence s_no_pop;
    !(result_valid && result_ready) [*2];
  endsequence
  a_gain_follows: assert property (gain_amplifier == gain_code)
    else $error("gain output differs");
  a_buf_internal: assert property (channel >= 4'hc
    |-> buf_en_p && buf_en_n)
    else $error("buffer off on internal channel");
  a_idle_quiet: assert property (!busy |-> !sample)
    else $error("sampling while idle");
  a_done_sticky: assert property (conv_done && !result_read
    |=> conv_done)
    else $error("done flag dropped unread");
  a_done_word: assert property ($rose(conv_done) |-> result_valid)
    else $error("done without a word");
  a_sw_start: assert property (sw_start && trig_sel == sac_pkg::SAC_TRIG_SW
    && !busy && !result_valid |=> sample)
    else $error("software start not taken");
  a_unsel_ignored: assert property (!busy && !continuous
    && trig_sel == sac_pkg::SAC_TRIG_PIN && !conversion_start_pin
    && !$past(conversion_start_pin) |=> !busy)
    else $error("start without selected trigger");
  a_word_stable: assert property (s_no_pop |=> $stable(conversion_result_word))
    else $error("result word changed without pop");
endmodule // sac_ctrl_asserts
bind sac_ctrl sac_ctrl_asserts sac_ctrl_asserts_inst (.mclk, .rst, .trig_sel,
  .continuous, .sw_start, .channel, .gain_code, .conversion_start_pin, .sample,
  .gain_amplifier, .buf_en_p, .buf_en_n, .conversion_result_word,
  .result_valid, .result_ready, .result_read, .conv_done, .busy);

// [sac_afe.sv]
// Comparator model of the analog front end
`timescale 1ns/1ps
module sac_afe (
  input  wire logic [11:0] vin,
  input  wire logic [11:0] dac_code,
  output logic             cmp_out
);
  // Keep the trial bit while the input is not below the trial code
  assign cmp_out = (dac_code <= vin);
endmodule // sac_afe

// [test_sar_adc_conversion_control.sv]
// Self-checking bench for the converter control
`timescale 1ns/1ps
module test_sar_adc_conversion_control;
  logic mclk = 0, rst = 1, continuous = 0, sw_start = 0, timing_load = 0;
  logic result_ready = 0, result_read = 0, cmp_out;
  logic sample, result_valid, conv_done, busy;
  logic chan_diff = 0, byp_p = 0, byp_n = 0, pair_diff, buf_en_p, buf_en_n;
  logic [3:0]  trg = 0, channel = 0, mux_sel;
  logic [4:0]  gain_code = 0, gain_amp;
  logic [7:0]  acq_clks = 8'h04, clk_div = 8'h00; // Zero divider loads as one
  logic [11:0] vin = 0, dac_code;
  logic [31:0] word, seed = 32'h7e4d;
  sac_pkg::sac_mode_t mode = sac_pkg::SAC_MODE_SINGLE;
  sac_pkg::sac_trig_t trig_sel = sac_pkg::SAC_TRIG_SW;
  int num_errors = 0, n_tests = 0, n;
  // Clock of 50 ns
  always #25 mclk = ~mclk;
  sac_ctrl sac_ctrl_inst (.mclk, .rst, .mode, .trig_sel, .continuous,
    .sw_start, .channel, .gain_code, .chan_diff, .buf_bypass_p(byp_p),
    .buf_bypass_n(byp_n), .timing_load, .acq_clks, .clk_div,
    .conversion_start_pin(trg[0]), .programmable_logic_array(trg[1]),
    .first_timer_overflow(trg[2]), .second_timer_overflow(trg[3]), .cmp_out,
    .dac_code, .sample, .mux_sel, .gain_amplifier(gain_amp), .pair_diff,
    .buf_en_p, .buf_en_n, .conversion_result_word(word), .result_valid,
    .result_ready, .result_read, .conv_done, .busy);
  sac_afe sac_afe_inst (.vin, .dac_code, .cmp_out);
  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // Expected upper half of the result word
  function automatic logic [15:0] exp_w(input sac_pkg::sac_mode_t m,
                                        input logic [11:0] v);
    logic [11:0] s;
    s = v ^ 12'h800;
    if (m == sac_pkg::SAC_MODE_DIFF) return {{5{s[11]}}, s[11:1]};
    return {4'h0, v};
  endfunction
  // Expected lower half of the result word
  function automatic logic [15:0] exp_l(input sac_pkg::sac_mode_t m,
                                        input logic [11:0] v);
    if (m == sac_pkg::SAC_MODE_DIFF) return {v[0], 15'h0000};
    return 16'h0000;
  endfunction
  // Expected pairing and buffer enables
  function automatic logic [2:0] exp_rt(input sac_pkg::sac_mode_t m,
                                        input logic dp, input logic [3:0] c,
                                        input logic bp, input logic bn);
    logic int_ch;
    int_ch = (c >= 4'hc);
    return {dp | (m == sac_pkg::SAC_MODE_DIFF), ~bp | int_ch, ~bn | int_ch};
  endfunction
  // Compare and count
  task automatic cmp(input logic [15:0] g, input logic [15:0] x);
    n_tests++;
    if (g !== x) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // Wait for a buffered word, counting cycles
  task automatic wait_word();
    n = 0;
    while (result_valid !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    cmp(16'(result_valid), 16'h1);
  endtask
  // Pop one word and check its contents
  task automatic pop();
    @(posedge mclk) result_ready <= 1;
    @(posedge mclk) result_ready <= 0;
    @(posedge mclk);
    @(negedge mclk) cmp(word[31:16], exp_w(mode, vin));
    cmp(word[15:0], exp_l(mode, vin));
  endtask
  // Read the done flag away
  task automatic clear();
    @(posedge mclk) result_read <= 1;
    @(posedge mclk) result_read <= 0;
    @(negedge mclk) cmp(16'(conv_done), 16'h0);
    $display("test done at %0t", $time);
  endtask
  // One conversion from source t, after a pulse on a wrong source when t is not 0
  task automatic conv(input int t);
    @(posedge mclk) trig_sel <= sac_pkg::sac_trig_t'(t);
    if (t > 0) begin
      @(posedge mclk) trg[t % 4] <= 1;
      @(posedge mclk) trg <= 0;
      repeat (2) @(negedge mclk);
      cmp(16'(busy), 16'h0);
    end
    @(posedge mclk);
    if (t == 0) sw_start <= 1;
    else trg[t-1] <= 1;
    @(posedge mclk) sw_start <= 0;
    trg <= 0;
    wait_word();
    cmp(16'(conv_done), 16'h1);
    pop();
    clear();
  endtask
  task automatic results();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #(50 * 80000);
    num_errors++;
    results();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 0;
    conv(0);
    cmp(16'(n > 40 && n < 70), 16'h1);
    @(posedge mclk) timing_load <= 1;
    @(posedge mclk) timing_load <= 0;
    conv(0);
    cmp(16'(n < 40), 16'h1);
    @(posedge mclk) channel <= 4'hf;
    conv(0);
    cmp(16'(n >= 512), 16'h1);
    @(posedge mclk) channel <= 4'h3;
    conv(0);
    cmp(16'(n < 40), 16'h1);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      @(posedge mclk) vin <= (i < 4) ? {i[0], {11{i[1]}}} : seed[11:0];
      mode <= sac_pkg::sac_mode_t'(i % 3);
      gain_code <= seed[20:16];
      channel <= seed[15:12];
      chan_diff <= seed[21];
      byp_p <= seed[22];
      byp_n <= seed[23];
      conv(i % 5);
      cmp({12'h000, mux_sel}, {12'h000, channel});
      cmp({11'h000, gain_amp}, {11'h000, gain_code});
      cmp({13'h0, pair_diff, buf_en_p, buf_en_n},
          {13'h0, exp_rt(mode, chan_diff, channel, byp_p, byp_n)});
    end
    @(posedge mclk) channel <= 4'h0;
    trig_sel <= sac_pkg::SAC_TRIG_PIN;
    @(posedge mclk) trg[0] <= 1;
    wait_word();
    pop();
    wait_word();
    pop();
    @(posedge mclk) trg <= 0;
    wait_word();
    pop();
    clear();
    @(posedge mclk) trig_sel <= sac_pkg::SAC_TRIG_SW;
    continuous <= 1;
    @(posedge mclk) sw_start <= 1;
    @(posedge mclk) sw_start <= 0;
    repeat (300) @(posedge mclk);
    continuous <= 0;
    repeat (3) begin
      wait_word();
      pop();
    end
    repeat (100) @(negedge mclk);
    cmp(16'(result_valid), 16'h0);
    clear();
    results();
  end
endmodule // test_sar_adc_conversion_control
